// ---- verilog/exec_unit_pkg.sv ----
// constants and types for the skip, swap, table-read and xor execution unit
package exec_unit_pkg;
    localparam int DATA_W        = 8;
    localparam int CODE_W        = 16;
    localparam int PAGE_ADDR_W   = 8;
    localparam int CODE_ADDR_W   = 13;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET   = 8'h00;
    localparam logic [2:0] SKIP_CYCLES   = 3'h2;

    typedef enum logic [3:0] {
        OP_NONE             = 4'h0,
        OP_NIBBLE_SWAP      = 4'h1,
        OP_SKIP_BYTE_CLEAR  = 4'h2,
        OP_SKIP_COPY_CLEAR  = 4'h3,
        OP_SKIP_BIT_CLEAR   = 4'h4,
        OP_PAGED_READ       = 4'h5,
        OP_CURRENT_READ     = 4'h6,
        OP_FINAL_READ       = 4'h7,
        OP_XOR_TO_WORKING   = 4'h8,
        OP_XOR_TO_MEMORY    = 4'h9,
        OP_XOR_IMMEDIATE    = 4'ha
    } op_e;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b00,
        ST_DUMMY = 2'b01,
        ST_TABLE = 2'b10
    } state_e;
endpackage : exec_unit_pkg

// ---- verilog/exec_unit.sv ----
// execution unit for nibble swap, zero-test skips, code table reads and xor
`timescale 1ns/100ps
`default_nettype none
module exec_unit
    import exec_unit_pkg::*;
#(
    parameter int ADDR_W = CODE_ADDR_W
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              issue_in,
    input  wire logic [3:0]        op_in,
    input  wire logic [7:0]        mem_byte_in,
    input  wire logic [2:0]        bit_sel_in,
    input  wire logic [7:0]        immediate_in,
    input  wire logic [7:0]        code_ptr_low_in,
    input  wire logic [7:0]        code_ptr_high_in,
    input  wire logic [ADDR_W-1:0] pc_in,
    input  wire logic [15:0]       code_word_in,
    output logic                   busy_out,
    output logic                   skip_out,
    output logic                   dummy_out,
    output logic [7:0]             working_register_out,
    output logic                   nil_flag_out,
    output logic                   mem_write_out,
    output logic [7:0]             mem_wdata_out,
    output logic                   code_read_out,
    output logic [ADDR_W-1:0]      code_addr_out,
    output logic [7:0]             code_high_latch_out
);
    localparam logic [ADDR_W-1:0] LAST_PAGE_BASE = {{(ADDR_W-PAGE_ADDR_W){1'b1}}, 8'h00};

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    state_e            state;
    state_e            next_state;
    logic [7:0]        working_register;
    logic [7:0]        next_working_register;
    logic              nil_flag;
    logic              next_nil_flag;
    logic              mem_write;
    logic              next_mem_write;
    logic [7:0]        mem_wdata;
    logic [7:0]        next_mem_wdata;
    logic              code_read;
    logic              next_code_read;
    logic [ADDR_W-1:0] code_addr;
    logic [ADDR_W-1:0] next_code_addr;
    logic [7:0]        code_high_latch;
    logic [7:0]        next_code_high_latch;
    logic              skip;
    logic              next_skip;
    logic              busy;
    logic              next_busy;
    logic [7:0]        xor_val;
    op_e               op;

    assign op = op_e'(op_in);

    always_comb begin
        next_state            = ST_EXEC;
        next_working_register = working_register;
        next_nil_flag         = nil_flag;
        next_mem_write        = 1'b0;
        next_mem_wdata        = mem_wdata;
        next_code_read        = 1'b0;
        next_code_addr        = code_addr;
        next_code_high_latch  = code_high_latch;
        next_skip             = 1'b0;
        xor_val               = 8'h00;
        case (state)
            ST_EXEC: begin
                if (issue_in) begin
                    case (op)
                        OP_NIBBLE_SWAP: begin
                            next_working_register = {mem_byte_in[3:0], mem_byte_in[7:4]};
                        end
                        OP_SKIP_BYTE_CLEAR: begin
                            next_skip = is_zero(mem_byte_in);
                        end
                        OP_SKIP_COPY_CLEAR: begin
                            next_working_register = mem_byte_in;
                            next_skip             = is_zero(mem_byte_in);
                        end
                        OP_SKIP_BIT_CLEAR: begin
                            next_skip = ~mem_byte_in[bit_sel_in];
                        end
                        OP_PAGED_READ: begin
                            next_code_read = 1'b1;
                            next_code_addr = ADDR_W'({code_ptr_high_in, code_ptr_low_in});
                            next_state     = ST_TABLE;
                        end
                        OP_CURRENT_READ: begin
                            next_code_read = 1'b1;
                            next_code_addr = {pc_in[ADDR_W-1:PAGE_ADDR_W], code_ptr_low_in};
                            next_state     = ST_TABLE;
                        end
                        OP_FINAL_READ: begin
                            next_code_read = 1'b1;
                            next_code_addr = LAST_PAGE_BASE | ADDR_W'(code_ptr_low_in);
                            next_state     = ST_TABLE;
                        end
                        OP_XOR_TO_WORKING, OP_XOR_TO_MEMORY, OP_XOR_IMMEDIATE: begin
                            xor_val = working_register ^
                                ((op == OP_XOR_IMMEDIATE) ? immediate_in : mem_byte_in);
                            next_nil_flag = is_zero(xor_val);
                            if (op == OP_XOR_TO_MEMORY) begin
                                next_mem_write = 1'b1;
                                next_mem_wdata = xor_val;
                            end else begin
                                next_working_register = xor_val;
                            end
                        end
                        default: begin
                            next_state = ST_EXEC;
                        end
                    endcase
                    if (next_skip) begin
                        next_state = ST_DUMMY;
                    end
                end
            end
            ST_DUMMY: begin
                // the fetched instruction is discarded; issue is ignored here
                next_state = ST_EXEC;
            end
            ST_TABLE: begin
                // program word is taken in the same cycle the address is presented
                next_mem_write       = 1'b1;
                next_mem_wdata       = code_word_in[7:0];
                next_code_high_latch = code_word_in[15:8];
                next_state           = ST_EXEC;
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
        // registered so the busy port comes straight from a flop
        next_busy = (next_state != ST_EXEC);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state            <= ST_EXEC;
            working_register <= WORKING_RESET;
            nil_flag         <= 1'b0;
            mem_write        <= 1'b0;
            mem_wdata        <= 8'h00;
            code_read        <= 1'b0;
            code_addr        <= '0;
            code_high_latch  <= LATCH_RESET;
            skip             <= 1'b0;
            busy             <= 1'b0;
        end else begin
            state            <= next_state;
            working_register <= next_working_register;
            nil_flag         <= next_nil_flag;
            mem_write        <= next_mem_write;
            mem_wdata        <= next_mem_wdata;
            code_read        <= next_code_read;
            code_addr        <= next_code_addr;
            code_high_latch  <= next_code_high_latch;
            skip             <= next_skip;
            busy             <= next_busy;
        end
    end

    assign working_register_out = working_register;
    assign nil_flag_out         = nil_flag;
    assign mem_write_out        = mem_write;
    assign mem_wdata_out        = mem_wdata;
    assign code_read_out        = code_read;
    assign code_addr_out        = code_addr;
    assign code_high_latch_out  = code_high_latch;
    assign skip_out             = skip;
    assign dummy_out            = skip;
    assign busy_out             = busy;

    skip_dummy_a: assert property (@(posedge clk_in) disable iff (rst_in)
        skip |-> busy && state == ST_DUMMY ##1 state == ST_EXEC)
        else $error("taken skip did not give one dummy cycle");
    swap_value_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_NIBBLE_SWAP |=>
        working_register == {$past(mem_byte_in[3:0]), $past(mem_byte_in[7:4])} && !skip
        && $stable(nil_flag))
        else $error("nibble swap result wrong");
    byte_skip_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_SKIP_BYTE_CLEAR |=>
        skip == ($past(mem_byte_in) == 8'h00) && $stable(nil_flag))
        else $error("byte clear skip wrong");
    copy_skip_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_SKIP_COPY_CLEAR |=>
        working_register == $past(mem_byte_in) && skip == (working_register == 8'h00))
        else $error("copy skip wrong");
    bit_skip_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_SKIP_BIT_CLEAR |=>
        skip == !$past(mem_byte_in[bit_sel_in]))
        else $error("bit test skip wrong");
    table_store_a: assert property (@(posedge clk_in) disable iff (rst_in)
        code_read |=> mem_write && mem_wdata == $past(code_word_in[7:0])
        && code_high_latch == $past(code_word_in[15:8]))
        else $error("table read store wrong");
    paged_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_PAGED_READ |=>
        code_read && code_addr == ADDR_W'({$past(code_ptr_high_in), $past(code_ptr_low_in)}))
        else $error("paged address wrong");
    current_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_CURRENT_READ |=>
        code_addr[7:0] == $past(code_ptr_low_in)
        && code_addr[ADDR_W-1:8] == $past(pc_in[ADDR_W-1:8]))
        else $error("current page address wrong");
    final_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_FINAL_READ |=>
        code_addr == (LAST_PAGE_BASE | ADDR_W'($past(code_ptr_low_in))))
        else $error("final page address wrong");
    xor_working_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_XOR_TO_WORKING |=>
        working_register == ($past(working_register) ^ $past(mem_byte_in))
        && nil_flag == (working_register == 8'h00))
        else $error("xor to working wrong");
    xor_memory_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_XOR_TO_MEMORY |=>
        mem_write && mem_wdata == ($past(working_register) ^ $past(mem_byte_in))
        && $stable(working_register) && nil_flag == (mem_wdata == 8'h00))
        else $error("xor to memory wrong");
    xor_imm_a: assert property (@(posedge clk_in) disable iff (rst_in)
        state == ST_EXEC && issue_in && op == OP_XOR_IMMEDIATE |=>
        working_register == ($past(working_register) ^ $past(immediate_in))
        && nil_flag == (working_register == 8'h00))
        else $error("xor immediate wrong");

    skip_taken_c: cover property (@(posedge clk_in) disable iff (rst_in) skip);
    table_done_c: cover property (@(posedge clk_in) disable iff (rst_in)
        code_read ##1 mem_write);
    nil_set_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(nil_flag));
endmodule : exec_unit
`default_nettype wire

// ---- bench/prog_mem_model.sv ----
// program memory model seen by the execution unit's code read port
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model
    import exec_unit_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   code_read_in,
    input  wire logic [CODE_ADDR_W-1:0] code_addr_in,
    output logic      [15:0]            code_word_out
);
    logic [15:0] noise = 16'h1234;
    // outside a read cycle the bus keeps changing, so a late sample never finds a stale word
    always @(posedge clk_in) begin
        noise <= ~noise ^ 16'h0101;
    end
    assign code_word_out = code_read_in ? {code_addr_in[7:0] ^ 8'hc3, code_addr_in[7:0]} : noise;
endmodule : prog_mem_model
`default_nettype wire

// ---- bench/skip_swap_table_xor_exec_tb.sv ----
// self-checking testbench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module skip_swap_table_xor_exec_tb;
    import exec_unit_pkg::*;
    logic                   clk_in = 1'b0;
    logic                   rst_in = 1'b1;
    logic                   issue_in = 1'b0;
    logic [3:0]             op_in = 4'h0;
    logic [7:0]             mem_byte_in = 8'h00;
    logic [2:0]             bit_sel_in = 3'h0;
    logic [7:0]             immediate_in = 8'h00;
    logic [7:0]             code_ptr_low_in = 8'h00;
    logic [7:0]             code_ptr_high_in = 8'h00;
    logic [CODE_ADDR_W-1:0] pc_in = '0;
    logic [15:0]            code_word_in;
    logic                   busy_out, skip_out, dummy_out, nil_flag_out, mem_write_out;
    logic                   code_read_out;
    logic [7:0]             working_register_out, mem_wdata_out, code_high_latch_out;
    logic [CODE_ADDR_W-1:0] code_addr_out;
    logic [7:0]             work = 8'h00;
    logic                   nil = 1'b0;
    int                     num_errors = 0;
    int                     checks_done = 0;

    exec_unit uut (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in),
        .mem_byte_in(mem_byte_in), .bit_sel_in(bit_sel_in), .immediate_in(immediate_in),
        .code_ptr_low_in(code_ptr_low_in), .code_ptr_high_in(code_ptr_high_in), .pc_in(pc_in),
        .code_word_in(code_word_in), .busy_out(busy_out), .skip_out(skip_out),
        .dummy_out(dummy_out), .working_register_out(working_register_out),
        .nil_flag_out(nil_flag_out), .mem_write_out(mem_write_out), .mem_wdata_out(mem_wdata_out),
        .code_read_out(code_read_out), .code_addr_out(code_addr_out),
        .code_high_latch_out(code_high_latch_out));
    prog_mem_model mem (.clk_in(clk_in), .code_read_in(code_read_out),
        .code_addr_in(code_addr_out), .code_word_out(code_word_in));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // drives one instruction for a single taking edge; returns where its results are settled
    task automatic issue(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b,
                         input logic [7:0] imm);
        @(negedge clk_in);
        issue_in = 1'b1;
        op_in = op;
        mem_byte_in = m;
        bit_sel_in = b;
        immediate_in = imm;
        @(negedge clk_in);
        issue_in = 1'b0;
    endtask : issue

    task automatic t_swap(input logic [7:0] m);
        issue(4'h1, m, 3'h0, 8'h00);
        work = {m[3:0], m[7:4]};
        chk("swap working", work, working_register_out);
        chk("swap nil", nil, nil_flag_out);
        chk("swap mem write", 1'b0, mem_write_out);
    endtask : t_swap

    task automatic t_skip(input logic [3:0] op, input logic [7:0] m, input logic [2:0] b,
                          input logic sk);
        issue(op, m, b, 8'h00);
        if (op == 4'h3) work = m;
        chk("skip", sk, skip_out);
        chk("dummy", sk, dummy_out);
        chk("busy", sk, busy_out);
        chk("skip working", work, working_register_out);
        chk("skip nil", nil, nil_flag_out);
        @(negedge clk_in);
        chk("skip one cycle", 1'b0, skip_out);
    endtask : t_skip

    task automatic t_table(input logic [3:0] op, input logic [7:0] hi, input logic [7:0] lo,
                           input logic [CODE_ADDR_W-1:0] pc, input logic [CODE_ADDR_W-1:0] a);
        code_ptr_high_in = hi;
        code_ptr_low_in = lo;
        pc_in = pc;
        issue(op, 8'h00, 3'h0, 8'h00);
        chk("code read", 1'b1, code_read_out);
        chk("code addr", a, code_addr_out);
        @(negedge clk_in);
        chk("table write", 1'b1, mem_write_out);
        chk("table low", lo, mem_wdata_out);
        chk("table high", lo ^ 8'hc3, code_high_latch_out);
        chk("table nil", nil, nil_flag_out);
    endtask : t_table

    task automatic t_xor(input logic [3:0] op, input logic [7:0] m, input logic [7:0] imm);
        logic [7:0] r;
        issue(op, m, 3'h0, imm);
        r = work ^ ((op == 4'ha) ? imm : m);
        if (op != 4'h9) work = r;
        nil = (r == 8'h00);
        chk("xor working", work, working_register_out);
        chk("xor nil", nil, nil_flag_out);
        chk("xor mem write", op == 4'h9, mem_write_out);
        if (op == 4'h9) chk("xor wdata", r, mem_wdata_out);
    endtask : t_xor

    // an xor held into the dummy cycle must be dropped, and an unknown opcode does nothing
    task automatic t_refuse();
        @(negedge clk_in);
        issue_in = 1'b1;
        op_in = 4'h2;
        mem_byte_in = 8'h00;
        @(negedge clk_in);
        chk("refuse skip", 1'b1, skip_out);
        op_in = 4'ha;
        immediate_in = 8'hff;
        @(negedge clk_in);
        issue_in = 1'b0;
        chk("refuse working", work, working_register_out);
        chk("refuse nil", nil, nil_flag_out);
        chk("refuse busy", 1'b0, busy_out);
        issue(4'hf, 8'hff, 3'h0, 8'hff);
        chk("unknown working", work, working_register_out);
        chk("unknown skip", 1'b0, skip_out);
        chk("unknown mem write", 1'b0, mem_write_out);
        chk("unknown code read", 1'b0, code_read_out);
    endtask : t_refuse

    // reset in mid-run must bring the working register, latch and flag back
    task automatic t_reset();
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        work = WORKING_RESET;
        nil = 1'b0;
        chk("rerun working", work, working_register_out);
        chk("rerun latch", LATCH_RESET, code_high_latch_out);
        chk("rerun nil", nil, nil_flag_out);
        chk("rerun busy", 1'b0, busy_out);
    endtask : t_reset

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        #20000;
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        chk("reset working", WORKING_RESET, working_register_out);
        t_swap(8'h3c);
        t_xor(4'h8, 8'hc3, 8'h00);
        t_xor(4'ha, 8'h00, 8'h5a);
        t_xor(4'h9, 8'h5a, 8'h00);
        t_swap(8'ha5);
        t_skip(4'h2, 8'h00, 3'h0, 1'b1);
        t_skip(4'h2, 8'h01, 3'h0, 1'b0);
        t_skip(4'h3, 8'h00, 3'h0, 1'b1);
        t_skip(4'h3, 8'h80, 3'h0, 1'b0);
        t_skip(4'h4, 8'hfe, 3'h0, 1'b1);
        t_skip(4'h4, 8'hfe, 3'h7, 1'b0);
        t_skip(4'h4, 8'h7f, 3'h7, 1'b1);
        t_table(4'h5, 8'h12, 8'h34, 13'h0000, 13'h1234);
        t_table(4'h6, 8'h00, 8'h56, 13'h0a11, 13'h0a56);
        t_table(4'h7, 8'h00, 8'h78, 13'h0000, 13'h1f78);
        t_xor(4'ha, 8'h00, 8'h7f);
        t_refuse();
        t_reset();
        t_xor(4'h9, 8'h3c, 8'h00);
        complete_run();
    end
endmodule : skip_swap_table_xor_exec_tb
`default_nettype wire
